//--- usp_pkg.sv
// Purpose : constants shared by the serial status, buffer and protect block
// Assumes : registers on one aligned 32-bit word each, index times four
// Notes   : byte-wide registers sit in the low lane, upper bits read zero
// ============================================================================
// package
package usp_pkg;

   // ========================================================================
   // bus geometry
   localparam int          ADDR_W       = 8;
   localparam int          IDX_W        = 6;
   localparam int          IDX_LSB      = 2;
   localparam int          LANE0        = 0;
   localparam logic [23:0] UPPER_ZERO   = 24'h000000;
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;

   // ========================================================================
   // register indices, byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_CTRL_ONE = 6'h1a;
   localparam logic [IDX_W-1:0] IDX_CTRL_TWO = 6'h1b;
   localparam logic [IDX_W-1:0] IDX_BAUD     = 6'h1c;
   localparam logic [IDX_W-1:0] IDX_STATUS   = 6'h1d;
   localparam logic [IDX_W-1:0] IDX_DATA     = 6'h1e;
   localparam logic [IDX_W-1:0] IDX_CLK_GATE = 6'h20;

   // ========================================================================
   // reset values and implemented-bit masks
   localparam logic [7:0] RST_BYTE      = 8'h00;
   localparam logic [7:0] CTRL_ONE_MASK = 8'hfe;
   localparam logic [7:0] CTRL_TWO_MASK = 8'h3f;
   localparam logic [7:0] NO_BITS       = 8'h00;

   // ========================================================================
   // serial_status field positions, bit 4 unused
   localparam int ST_PARITY  = 7;
   localparam int ST_FRAMING = 6;
   localparam int ST_OVERRUN = 5;
   localparam int ST_RX_BUSY = 3;
   localparam int ST_RX_FULL = 2;
   localparam int ST_TX_BUSY = 1;
   localparam int ST_TX_FULL = 0;

   // ========================================================================
   // serial_control_one field positions
   localparam int C1_TX_EN    = 7;
   localparam int C1_RX_EN    = 6;
   localparam int C1_TX_STOP2 = 5;
   localparam int C1_EVEN     = 4;
   localparam int C1_PAR_ADD  = 3;
   localparam int C1_IR_SEL   = 2;
   localparam int C1_BASE_SEL = 1;

   // ========================================================================
   // serial_control_two field positions
   localparam int C2_RT_LSB    = 3;
   localparam int C2_RT_MSB    = 5;
   localparam int C2_NC_LSB    = 1;
   localparam int C2_NC_MSB    = 2;
   localparam int C2_RX_STOP2  = 0;

   // peripheral_clock_gate_reg field
   localparam int CG_SERIAL_EN = 0;

endpackage : usp_pkg

//--- usp_core.sv
// Purpose : status flags, data buffers, clock gate and config write-protect
// Assumes : engine events are same-clock pulses and levels, no sync needed
// Notes   : AXI4-Lite slave, one write and one read in flight at a time
// ============================================================================
// Function
// [RL1] status bit 7 shows parity mismatch of the latest received frame
// [RL2] status bit 6 shows invalid stop bit of the latest frame
// [RL3] status bit 5 shows a byte arriving before the previous was read
// [RL4] status bit 3 is high while a frame is being received
// [RL5] status bit 2 is high while the receive buffer holds unread data
// [RL6] status bit 1 is high while a frame is being shifted out
// [RL7] status bit 0 shows a written byte not yet taken for sending
// [RL8] transmit full sets on buffer write, clears when transmit request rises
// [RL9] status bit 4 reads zero, all status read-only and reset zero
// [RL10] low-power entry clears every status bit and halts the serial unit
// [RL11] data buffers are don't-care after low-power entry
// [RL12] software reads wanted receive data before low-power entry
// [RL13] clock enable low stops the unit, high lets it run
// [RL14] clock enable resets to zero, unit unusable until enabled
// [RL15] software enables the clock before touching control registers
// [RL16] software keeps clock enable high while a transfer runs
// [RL17] a protected bit written while locked keeps its old value
// [RL18] transmit stop length writable only with transmit enable and busy low
// [RL19] parity bits writable only with all enables and busy flags low
// [RL20] output encoding select writable only with transmit side idle
// [RL21] bit-period count field writable only with all four conditions low
// [RL22] noise rejection field writable only with receive side idle
// [RL23] receive stop length writable only with receive side idle
// [RL24] base clock select writable only with all four conditions low
// [RL25] shared data address reads receive buffer, writes transmit buffer
// [RL26] enable cleared mid-frame acts after the frame, pending byte dropped
module usp_core (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   input  wire logic        lp_entry,
   input  wire logic        tx_active,
   input  wire logic        tx_taken,
   input  wire logic        rx_active,
   input  wire logic        rx_done,
   input  wire logic [7:0]  rx_byte,
   input  wire logic        rx_parity_bad,
   input  wire logic        rx_stop_bad,
   output logic             clk_supply,
   output logic             tx_run,
   output logic             rx_run,
   output logic [7:0]       tx_byte,
   output logic             tx_byte_ready,
   output logic             tx_request,
   output logic [7:0]       ctrl_one_out,
   output logic [7:0]       ctrl_two_out,
   output logic [7:0]       baud_divisor
);

   // ========================================================================
   // storage
   logic [7:0]  ctrl_one;
   logic [7:0]  ctrl_two;
   logic [7:0]  baud;
   logic [7:0]  rx_buf;
   logic        gate_on;
   logic        parity_fault_flag;
   logic        framing_fault_flag;
   logic        overrun_fault_flag;
   logic        rx_busy;
   logic        receive_holding_full;
   logic        tx_busy;
   logic        transmit_holding_full;
   logic        aw_full;
   logic        w_full;
   logic [7:0]  aw_addr_q;
   logic [7:0]  w_byte_q;
   logic        w_lane_q;
   logic [5:0]  rd_idx_q;

   // ========================================================================
   // decode
   logic [5:0]  wr_idx;
   logic [5:0]  rd_idx;
   logic        wr_go;
   logic        wr_en;
   logic        rd_take;
   logic        rx_ok;
   logic        overrun;
   logic        rx_read;
   logic        tx_idle;
   logic        rx_idle;
   logic        all_idle;
   logic [7:0]  m_one;
   logic [7:0]  m_two;
   logic [7:0]  next_rd_byte;
   logic        next_rd_hit;
   logic        wr_hit;
   logic [7:0]  status_byte;

   assign wr_idx  = aw_addr_q[usp_pkg::IDX_LSB +: usp_pkg::IDX_W];
   assign rd_idx  = araddr[usp_pkg::IDX_LSB +: usp_pkg::IDX_W];
   assign wr_go   = aw_full && w_full && !bvalid;
   // lane 0 carries every byte-wide register
   assign wr_en   = wr_go && w_lane_q;
   assign rd_take = arvalid && arready;
   // engine events are ignored while the unit clock is gated
   assign rx_ok   = gate_on && rx_done && !lp_entry; // [RL13]
   assign rx_read = rd_take && gate_on && (rd_idx == usp_pkg::IDX_DATA);
   assign overrun = rx_ok && receive_holding_full && !rx_read; // [RL3]

   // lock conditions use the values before this write
   assign tx_idle  = !ctrl_one[usp_pkg::C1_TX_EN] && !tx_busy;
   assign rx_idle  = !ctrl_one[usp_pkg::C1_RX_EN] && !rx_busy;
   assign all_idle = tx_idle && rx_idle;

   // status word, bit 4 held at zero
   assign status_byte = {parity_fault_flag, framing_fault_flag,
                         overrun_fault_flag, 1'b0, rx_busy,
                         receive_holding_full, tx_busy,
                         transmit_holding_full}; // [RL9]

   // write-permission masks, locked bits keep old value
   always_comb begin
      m_one = usp_pkg::NO_BITS;
      m_two = usp_pkg::NO_BITS;
      m_one[usp_pkg::C1_TX_EN] = 1'b1;
      m_one[usp_pkg::C1_RX_EN] = 1'b1;
      if (tx_idle) begin
         m_one[usp_pkg::C1_TX_STOP2] = 1'b1; // [RL18]
         m_one[usp_pkg::C1_IR_SEL]   = 1'b1; // [RL20]
      end
      if (all_idle) begin
         m_one[usp_pkg::C1_EVEN]     = 1'b1; // [RL19]
         m_one[usp_pkg::C1_PAR_ADD]  = 1'b1; // [RL19]
         m_one[usp_pkg::C1_BASE_SEL] = 1'b1; // [RL24]
         m_two[usp_pkg::C2_RT_MSB:usp_pkg::C2_RT_LSB] = 3'h7; // [RL21]
      end
      if (rx_idle) begin
         m_two[usp_pkg::C2_NC_MSB:usp_pkg::C2_NC_LSB] = 2'h3; // [RL22]
         m_two[usp_pkg::C2_RX_STOP2] = 1'b1; // [RL23]
      end
   end

   // unit registers only accept writes with the clock supplied
   always_comb begin
      wr_hit = 1'b1;
      case (wr_idx)
         usp_pkg::IDX_CTRL_ONE,
         usp_pkg::IDX_CTRL_TWO,
         usp_pkg::IDX_BAUD,
         usp_pkg::IDX_STATUS,
         usp_pkg::IDX_DATA,
         usp_pkg::IDX_CLK_GATE: wr_hit = 1'b1;
         default:               wr_hit = 1'b0;
      endcase
   end

   // read mux, shared data address reads the receive side
   always_comb begin
      next_rd_byte = usp_pkg::RST_BYTE;
      next_rd_hit  = 1'b1;
      case (rd_idx)
         usp_pkg::IDX_CTRL_ONE: next_rd_byte = ctrl_one;
         usp_pkg::IDX_CTRL_TWO: next_rd_byte = ctrl_two;
         usp_pkg::IDX_BAUD:     next_rd_byte = baud;
         usp_pkg::IDX_STATUS:   next_rd_byte = status_byte;
         usp_pkg::IDX_DATA:     next_rd_byte = rx_buf; // [RL25]
         usp_pkg::IDX_CLK_GATE: next_rd_byte = {7'h00, gate_on};
         default:               next_rd_hit  = 1'b0;
      endcase
   end

   // ========================================================================
   // axi write channels, address and data taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full   <= 1'b0;
         awready   <= 1'b0;
         aw_addr_q <= usp_pkg::RST_BYTE;
      end else if (awvalid && awready) begin
         aw_full   <= 1'b1;
         awready   <= 1'b0;
         aw_addr_q <= awaddr;
      end else if (bvalid && bready) begin
         aw_full   <= 1'b0;
         awready   <= 1'b1;
      end else if (!aw_full) begin
         awready   <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_full   <= 1'b0;
         wready   <= 1'b0;
         w_byte_q <= usp_pkg::RST_BYTE;
         w_lane_q <= 1'b0;
      end else if (wvalid && wready) begin
         w_full   <= 1'b1;
         wready   <= 1'b0;
         w_byte_q <= wdata[7:0];
         w_lane_q <= wstrb[usp_pkg::LANE0];
      end else if (bvalid && bready) begin
         w_full   <= 1'b0;
         wready   <= 1'b1;
      end else if (!w_full) begin
         wready   <= 1'b1;
      end
   end

   // response once both halves are held
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp  <= usp_pkg::RESP_OKAY;
      end else if (wr_go) begin
         bvalid <= 1'b1;
         bresp  <= wr_hit ? usp_pkg::RESP_OKAY : usp_pkg::RESP_SLVERR;
      end else if (bvalid && bready) begin
         bvalid <= 1'b0;
      end
   end

   // ========================================================================
   // axi read channel, one beat per address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready  <= 1'b0;
         rvalid   <= 1'b0;
         rdata    <= {usp_pkg::UPPER_ZERO, usp_pkg::RST_BYTE};
         rresp    <= usp_pkg::RESP_OKAY;
         rd_idx_q <= 6'h00;
      end else if (rd_take) begin
         arready  <= 1'b0;
         rvalid   <= 1'b1;
         rdata    <= {usp_pkg::UPPER_ZERO, next_rd_byte};
         rresp    <= next_rd_hit ? usp_pkg::RESP_OKAY : usp_pkg::RESP_SLVERR;
         rd_idx_q <= rd_idx;
      end else if (rvalid && rready) begin
         rvalid   <= 1'b0;
         arready  <= 1'b1;
      end else if (!rvalid) begin
         arready  <= 1'b1;
      end
   end

   // ========================================================================
   // clock gate, always writable so software can wake the unit
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         gate_on <= 1'b0; // [RL14]
      end else if (wr_en && wr_idx == usp_pkg::IDX_CLK_GATE) begin
         gate_on <= w_byte_q[usp_pkg::CG_SERIAL_EN]; // [RL13]
      end
   end

   // control one, enables drop on low-power entry, others hold
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_one <= usp_pkg::RST_BYTE;
      end else if (lp_entry) begin
         ctrl_one[usp_pkg::C1_TX_EN] <= 1'b0; // [RL10]
         ctrl_one[usp_pkg::C1_RX_EN] <= 1'b0; // [RL10]
      end else if (gate_on && wr_en && wr_idx == usp_pkg::IDX_CTRL_ONE) begin
         ctrl_one <= ((ctrl_one & ~m_one) | (w_byte_q & m_one))
                     & usp_pkg::CTRL_ONE_MASK; // [RL17]
      end
   end

   // control two, all fields protected
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_two <= usp_pkg::RST_BYTE;
      end else if (gate_on && wr_en && wr_idx == usp_pkg::IDX_CTRL_TWO) begin
         ctrl_two <= ((ctrl_two & ~m_two) | (w_byte_q & m_two))
                     & usp_pkg::CTRL_TWO_MASK; // [RL17]
      end
   end

   // baud divisor, unprotected by design
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         baud <= usp_pkg::RST_BYTE;
      end else if (gate_on && wr_en && wr_idx == usp_pkg::IDX_BAUD) begin
         baud <= w_byte_q;
      end
   end

   // ========================================================================
   // receive side: errors describe the latest frame only
   always_ff @(posedge aclk) begin
      if (!aresetn || lp_entry) begin
         parity_fault_flag  <= 1'b0; // [RL10]
         framing_fault_flag <= 1'b0;
         overrun_fault_flag <= 1'b0;
      end else if (rx_ok) begin
         parity_fault_flag  <= rx_parity_bad; // [RL1]
         framing_fault_flag <= rx_stop_bad; // [RL2]
         overrun_fault_flag <= overrun; // [RL3]
      end
   end

   // an overrun keeps the unread byte, the late one is lost
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_buf <= usp_pkg::RST_BYTE;
      end else if (rx_ok && !overrun) begin
         rx_buf <= rx_byte; // [RL11]
      end
   end

   // receive full, new byte wins over a read in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn || lp_entry) begin
         receive_holding_full <= 1'b0; // [RL10]
      end else if (rx_ok) begin
         receive_holding_full <= 1'b1; // [RL5]
      end else if (rx_read) begin
         receive_holding_full <= 1'b0; // [RL5]
      end
   end

   // busy flags follow the engine, frozen while gated
   always_ff @(posedge aclk) begin
      if (!aresetn || lp_entry) begin
         rx_busy <= 1'b0; // [RL10]
         tx_busy <= 1'b0;
      end else if (gate_on) begin
         rx_busy <= rx_active; // [RL4]
         tx_busy <= tx_active; // [RL6]
      end
   end

   // ========================================================================
   // transmit side: buffer, request pulse and full flag
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_byte <= usp_pkg::RST_BYTE;
      end else if (gate_on && wr_en && wr_idx == usp_pkg::IDX_DATA) begin
         tx_byte <= w_byte_q; // [RL25]
      end
   end

   // request only for a byte really pending
   always_ff @(posedge aclk) begin
      if (!aresetn || lp_entry) begin
         tx_request <= 1'b0;
      end else begin
         tx_request <= gate_on && tx_taken && transmit_holding_full;
      end
   end

   // set by write wins, cleared by request or by dropping transmit enable
   always_ff @(posedge aclk) begin
      if (!aresetn || lp_entry) begin
         transmit_holding_full <= 1'b0; // [RL10]
      end else if (gate_on && wr_en && wr_idx == usp_pkg::IDX_DATA) begin
         transmit_holding_full <= 1'b1; // [RL7]
      end else if (tx_request) begin
         transmit_holding_full <= 1'b0; // [RL8]
      end else if (gate_on && wr_en && wr_idx == usp_pkg::IDX_CTRL_ONE
                   && !w_byte_q[usp_pkg::C1_TX_EN]) begin
         transmit_holding_full <= 1'b0; // [RL26]
      end
   end

   // engine run levels stretch to the end of the current frame
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_run     <= 1'b0;
         rx_run     <= 1'b0;
         clk_supply <= 1'b0;
      end else begin
         tx_run     <= gate_on && (ctrl_one[usp_pkg::C1_TX_EN] || tx_active);
         rx_run     <= gate_on && (ctrl_one[usp_pkg::C1_RX_EN] || rx_active);
         clk_supply <= gate_on; // [RL13]
      end
   end

   assign tx_byte_ready = transmit_holding_full;
   assign ctrl_one_out  = ctrl_one;
   assign ctrl_two_out  = ctrl_two;
   assign baud_divisor  = baud;

   // ========================================================================
   // checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_parity_track : assert property ( // [RL1]
      rx_ok |=> parity_fault_flag == $past(rx_parity_bad))
      else $error("parity flag not following latest frame");

   a_framing_track : assert property ( // [RL2]
      rx_ok |=> framing_fault_flag == $past(rx_stop_bad))
      else $error("framing flag not following latest frame");

   a_overrun_set : assert property ( // [RL3]
      rx_ok && receive_holding_full && !rx_read |=> overrun_fault_flag)
      else $error("overrun not flagged");

   a_rx_full_set : assert property ( // [RL5]
      rx_ok |=> receive_holding_full
                && (rx_buf == $past(rx_byte) || $past(overrun)))
      else $error("receive full not set by new byte");

   a_busy_follow : assert property ( // [RL4]
      gate_on && !lp_entry |=> rx_busy == $past(rx_active)
                               && tx_busy == $past(tx_active))
      else $error("busy flags not following engine");

   a_status_bit4 : assert property ( // [RL9]
      rvalid && rd_idx_q == usp_pkg::IDX_STATUS |-> rdata[4] == 1'b0)
      else $error("status bit 4 not zero");

   a_tx_full_set : assert property ( // [RL7]
      gate_on && wr_en && wr_idx == usp_pkg::IDX_DATA && !lp_entry
      |=> transmit_holding_full)
      else $error("transmit full not set by write");

   a_tx_full_clear : assert property ( // [RL8]
      gate_on && tx_taken && transmit_holding_full && !lp_entry
      |=> tx_request ##1 (!transmit_holding_full || $past(wr_en)))
      else $error("transmit full not cleared by request");

   a_lp_clear : assert property ( // [RL10]
      lp_entry |=> status_byte == usp_pkg::RST_BYTE
                   && !ctrl_one[usp_pkg::C1_TX_EN]
                   && !ctrl_one[usp_pkg::C1_RX_EN])
      else $error("low-power entry left status or enables set");

   a_stop_lock : assert property ( // [RL18]
      wr_en && wr_idx == usp_pkg::IDX_CTRL_ONE && !tx_idle
      |=> $stable(ctrl_one[usp_pkg::C1_TX_STOP2])
          && $stable(ctrl_one[usp_pkg::C1_IR_SEL]))
      else $error("transmit-locked bit changed");

   a_parity_lock : assert property ( // [RL19]
      wr_en && wr_idx == usp_pkg::IDX_CTRL_ONE && !all_idle
      |=> $stable(ctrl_one[usp_pkg::C1_EVEN])
          && $stable(ctrl_one[usp_pkg::C1_PAR_ADD]))
      else $error("parity bit changed while locked");

   a_ctrl_two_lock : assert property ( // [RL21]
      wr_en && wr_idx == usp_pkg::IDX_CTRL_TWO && !all_idle
      |=> $stable(ctrl_two[usp_pkg::C2_RT_MSB:usp_pkg::C2_RT_LSB]))
      else $error("bit-period field changed while locked");

   a_gate_freeze : assert property ( // [RL13]
      !gate_on && !lp_entry |=> $stable(receive_holding_full)
                                && $stable(rx_busy))
      else $error("status moved with clock gated off");

   c_write_read : cover property (
      wr_en && wr_idx == usp_pkg::IDX_DATA ##[1:20] tx_request);
   c_overrun : cover property (rx_ok && overrun);
   c_locked_write : cover property (
      wr_en && wr_idx == usp_pkg::IDX_CTRL_TWO && !rx_idle);
   c_lp_entry : cover property (lp_entry && receive_holding_full);

endmodule : usp_core

//--- usp_core_end.sv
// Purpose : none
// Assumes : none
// Notes   : none

//--- usp_engine_model.sv
// Purpose : serial engine stand-in driving frame events
// Assumes : every frame lasts twenty clock cycles
// Notes   : result lines are scrambled outside the done pulse
// ======================================
module usp_engine_model (
   input  wire logic       aclk,
   input  wire logic       start_tx,
   input  wire logic       start_rx,
   input  wire logic [9:0] rx_in,
   input  wire logic       tx_byte_ready,
   output logic            tx_active,
   output logic            tx_taken,
   output logic            rx_active,
   output logic            rx_done,
   output logic [7:0]      rx_byte,
   output logic            rx_parity_bad,
   output logic            rx_stop_bad
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [4:0] tx_cnt = 5'h00;
   logic [4:0] rx_cnt = 5'h00;
   logic [9:0] frm;
   assign tx_active = |tx_cnt;
   assign rx_active = |rx_cnt;
   // only a byte really offered is taken
   always @(posedge aclk) begin
      tx_taken <= start_tx & tx_byte_ready;
      tx_cnt <= (start_tx & tx_byte_ready) ? 5'h14 : tx_cnt - tx_active;
   end
   // no stale value may pass for a result between frames
   always @(posedge aclk) begin
      rx_done <= (rx_cnt == 5'h01);
      frm <= start_rx ? rx_in : frm;
      rx_cnt <= start_rx ? 5'h14 : rx_cnt - rx_active;
      {rx_parity_bad, rx_stop_bad, rx_byte} <=
         (rx_cnt == 5'h01) ? frm : ~frm ^ {5'h00, rx_cnt};
   end
endmodule : usp_engine_model

//--- usp_core_bench.sv
// Purpose : self-checking bench of the status, buffer and protect block
// Assumes : engine model frames take twenty cycles
// Notes   : random bytes come from a fixed-seed shift register
module usp_core_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic        aclk = 1'b0;
   logic        aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic        lp_entry, start_tx, start_rx, awready, wready, bvalid;
   logic        arready, rvalid, tx_active, tx_taken, rx_active, rx_done;
   logic        rx_parity_bad, rx_stop_bad, tx_byte_ready, tx_request;
   logic        req_seen, cs, tr, rr;
   logic [1:0]  bresp, rresp, r, pf;
   logic [3:0]  wstrb;
   logic [7:0]  awaddr, araddr, rx_byte, tx_byte, b0, c1, c2, bd;
   logic [9:0]  rx_in;
   logic [31:0] wdata, rdata, seed;
   logic [7:0]  pa [6] = '{8'h68, 8'h68, 8'h6c, 8'h68, 8'h6c, 8'h68};
   logic [7:0]  pv [6] = '{8'h40, 8'h7e, 8'h3f, 8'h80, 8'h3f, 8'hff};
   logic [7:0]  pe [6] = '{8'h40, 8'h64, 8'h00, 8'h80, 8'h07, 8'hc0};
   int          num_errors = 0;
   int          compares = 0;
   // ======================================
   // clock, design, engine
   always #50 aclk = ~aclk;
   always @(posedge aclk) req_seen <= aresetn & (req_seen | tx_request);
   usp_core dut_u (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
      .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
      .arready, .rdata, .rresp, .rvalid, .rready, .lp_entry, .tx_active,
      .tx_taken, .rx_active, .rx_done, .rx_byte, .rx_parity_bad,
      .rx_stop_bad, .clk_supply(cs), .tx_run(tr), .rx_run(rr), .tx_byte,
      .tx_byte_ready, .tx_request, .ctrl_one_out(c1), .ctrl_two_out(c2),
      .baud_divisor(bd));
   usp_engine_model eng_u (.aclk, .start_tx, .start_rx, .rx_in,
      .tx_byte_ready, .tx_active, .tx_taken, .rx_active, .rx_done,
      .rx_byte, .rx_parity_bad, .rx_stop_bad);
   // ======================================
   // expectations and reporting
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   // status word from {parity, framing, overrun, rbusy, rfull, tbusy, tfull}
   function automatic logic [31:0] st(input logic [6:0] f);
      return {24'h000000, f[6:4], 1'b0, f[3:0]};
   endfunction : st
   task automatic final_report;
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : final_report
   task automatic chk(input string n, input logic [31:0] e, g);
      compares++;
      if (g !== e) begin
         num_errors++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // ======================================
   // bus tasks, every wait bounded
   task automatic wr(input logic [7:0] a, v);
      int n;
      @(posedge aclk);
      {awaddr, wdata} <= {a, 24'h000000, v};
      {awvalid, wvalid, bready} <= 3'h7;
      for (n = 0; n < 40 && bvalid !== 1'b1; n++) begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end
      if (n == 40) chk("bvalid", 32'h1, 32'h0);
      if (n == 40) final_report();
      r = bresp;
      bready <= 1'b0;
   endtask : wr
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      int n;
      @(posedge aclk);
      araddr <= a;
      {arvalid, rready} <= 2'h3;
      for (n = 0; n < 40 && rvalid !== 1'b1; n++) begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end
      if (n == 40) chk("rvalid", 32'h1, 32'h0);
      if (n == 40) final_report();
      rready <= 1'b0;
      chk($sformatf("reg %h", a), e, rdata);
   endtask : rc
   // start a frame, clock gate left on throughout
   task automatic kick(input logic [9:0] v, input logic t);
      @(posedge aclk);
      rx_in <= v;
      {start_tx, start_rx} <= {t, !t};
      @(posedge aclk);
      {start_tx, start_rx} <= 2'h0;
      repeat (4) @(posedge aclk);
   endtask : kick
   // ======================================
   // main sequence
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
      {lp_entry, start_tx, start_rx, pf, wstrb} = 9'h00f;
      {awaddr, araddr, rx_in, wdata} = 58'h0;
      seed = 32'hd1596543;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      rc(8'h74, 32'h0);
      rc(8'h80, 32'h0);
      wr(8'h68, 8'h40);
      rc(8'h68, 32'h0);
      wr(8'h80, 8'h01);
      wr(8'h74, 8'hff);
      rc(8'h74, 32'h0);
      wr(8'h44, 8'h00);
      chk("resp", 32'h2, {30'h0, r});
      for (int i = 0; i < 6; i++) begin
         wr(pa[i], pv[i]);
         rc(pa[i], {24'h0, pe[i]});
      end
      wr(8'h70, 8'h5a);
      chk("run_levels", 32'h7, {29'h0, cs, tr, rr});
      chk("ctrl_outs", 32'h00c0075a, {8'h0, c1, c2, bd});
      seed = lfsr(seed);
      wr(8'h78, seed[7:0]);
      chk("tx_byte", {24'h0, seed[7:0]}, {24'h0, tx_byte});
      rc(8'h74, st(7'h01));
      kick(10'h000, 1'b1);
      rc(8'h74, st(7'h02));
      chk("tx_request", 32'h1, {31'h0, req_seen});
      repeat (25) @(posedge aclk);
      rc(8'h74, 32'h0);
      for (int k = 0; k < 4; k++) begin
         seed = lfsr(seed);
         kick({k[1:0], seed[7:0]}, 1'b0);
         rc(8'h74, st({pf, 5'h08}));
         repeat (25) @(posedge aclk);
         rc(8'h74, st({k[1:0], 5'h04}));
         rc(8'h78, {24'h0, seed[7:0]});
         rc(8'h74, st({k[1:0], 5'h00}));
         pf = k[1:0];
      end
      seed = lfsr(seed);
      b0 = seed[7:0];
      kick({2'h0, b0}, 1'b0);
      repeat (25) @(posedge aclk);
      kick({2'h3, ~b0}, 1'b0);
      repeat (25) @(posedge aclk);
      rc(8'h74, st(7'h74));
      rc(8'h78, {24'h0, b0});
      wr(8'h78, b0);
      wr(8'h68, 8'h40);
      rc(8'h74, st(7'h70));
      @(posedge aclk);
      lp_entry <= 1'b1;
      @(posedge aclk);
      lp_entry <= 1'b0;
      rc(8'h74, 32'h0);
      rc(8'h68, 32'h0);
      final_report();
   end
endmodule : usp_core_bench
